// File: design/nco_params.svh
`ifndef NCO_PARAMS_SVH
`define NCO_PARAMS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_CONTROL 4'h0
`define OFS_CLOCK_CTRL 4'h1
`define OFS_ACC_LOW 4'h2
`define OFS_ACC_HIGH 4'h3
`define OFS_ACC_UPPER 4'h4
`define OFS_INC_LOW 4'h5
`define OFS_INC_HIGH 4'h6
`define OFS_INC_UPPER 4'h7

// ----------------------------------------
// field positions
// ----------------------------------------
`define BIT_ENABLE 7
`define BIT_OUT_STATUS 5
`define BIT_POLARITY 4
`define BIT_PFM 0
`define PWS_MSB 7
`define PWS_LSB 5
`define CKS_MSB 2
`define CKS_LSB 0

// ----------------------------------------
// reset values and clock codes
// ----------------------------------------
`define RST_INC 20'h00001
`define RST_ACC 20'h00000
`define CKS_SYSTEM 3'h0
`define CKS_FAST_OSC 3'h1
`define CKS_LC_FIRST 3'h2
`define CKS_LC_LAST 3'h5
`define SRC_COUNT 5

`endif

// File: design/nco_pkg.sv
package nco_pkg;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    typedef struct packed {
        logic [4:0] q1;
        logic [4:0] q2;
        logic [4:0] q3;
        logic [4:0] level;
        logic [4:0] rise;
        logic [4:0] fall;
    } sync_state_t;

    typedef struct packed {
        logic enable;
        logic polarity;
        logic pfm;
        logic [2:0] pws;
        logic [2:0] cks;
        logic [19:0] acc;
        logic [19:0] inc;
        logic [19:0] increment_buffer;
        logic inc_pending;
        logic out;
        logic [7:0] width_cnt;
        logic pin;
        logic [7:0] rdata;
    } nco_state_t;

endpackage

// File: design/clock_source_sync.sv
`timescale 1ns/1ps
module clock_source_sync
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [4:0] src,
    output logic [4:0] rise,
    output logic [4:0] fall
);
    import nco_pkg::*;

    sync_state_t st;
    sync_state_t next_st;

    // ----------------------------------------
    // three-stage sampling, change accepted when stages two and three agree
    // ----------------------------------------
    always_comb
    begin
        next_st = st;
        next_st.q1 = src;
        next_st.q2 = st.q1;
        next_st.q3 = st.q2;
        for (int i = 0; i < 5; i++)
        begin
            if (st.q2[i] == st.q3[i])
            begin
                next_st.level[i] = st.q3[i];
            end
            next_st.rise[i] = (st.q2[i] == st.q3[i]) && st.q3[i] && !st.level[i];
            next_st.fall[i] = (st.q2[i] == st.q3[i]) && !st.q3[i] && st.level[i];
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign rise = st.rise;
    assign fall = st.fall;
endmodule

// File: design/numeric_oscillator.sv
`timescale 1ns/1ps
`include "nco_params.svh"
module numeric_oscillator
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire nco_pkg::bus_req_t BUS,
    output logic [7:0] RDATA,
    input wire logic FAST_OSC,
    input wire logic [3:0] LC_OUT,
    output logic NCO_OUT
);
    import nco_pkg::*;

    logic [1:0] rst_pipe;
    logic rst_n;
    logic [4:0] src_rise;
    logic [4:0] src_fall;
    logic tick_rise;
    logic tick_fall;
    logic [20:0] sum;
    logic overflow;
    logic acc_written;
    nco_state_t st;
    nco_state_t next_st;

    // ----------------------------------------
    // reset release
    // ----------------------------------------
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            rst_pipe <= 2'h0;
        end
        else
        begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe[1];

    // ----------------------------------------
    // input clock selection
    // ----------------------------------------
    clock_source_sync u_sync
    (
        .clk(CLK),
        .rst_n(rst_n),
        .src({LC_OUT, FAST_OSC}),
        .rise(src_rise),
        .fall(src_fall)
    );

    function automatic logic pick(input logic [2:0] cks, input logic [4:0] edges);
        // system clock gives an edge every cycle; reserved codes give none
        if (cks == `CKS_SYSTEM)
        begin
            return 1'b1;
        end
        else if (cks <= `CKS_LC_LAST)
        begin
            return edges[cks - 3'h1];
        end
        else
        begin
            return 1'b0;
        end
    endfunction

    assign tick_rise = pick(st.cks, src_rise);
    assign tick_fall = pick(st.cks, src_fall);
    assign sum = {1'b0, st.acc} + {1'b0, st.increment_buffer};
    assign overflow = st.enable && tick_rise && sum[20];
    assign acc_written = BUS.wr && (BUS.addr >= `OFS_ACC_LOW) && (BUS.addr <= `OFS_ACC_UPPER);

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb
    begin
        next_st = st;
        // accumulator moves on the input clock, independent of bus reads
        if (st.enable && tick_rise)
        begin
            next_st.acc = sum[19:0];
        end
        if (tick_fall && st.inc_pending)
        begin
            next_st.increment_buffer = st.inc;
            next_st.inc_pending = 1'b0;
        end
        if (!st.enable)
        begin
            next_st.out = 1'b0;
            next_st.width_cnt = 8'h00;
        end
        else if (overflow && !st.pfm)
        begin
            next_st.out = !st.out;
        end
        else if (overflow)
        begin
            // a new overflow mid-pulse restarts it; software avoids that case
            next_st.out = 1'b1;
            next_st.width_cnt = 8'((9'h001 << st.pws) - 9'h001);
        end
        else if (st.pfm && tick_rise && st.out)
        begin
            if (st.width_cnt == 8'h00)
            begin
                next_st.out = 1'b0;
            end
            else
            begin
                next_st.width_cnt = st.width_cnt - 8'h01;
            end
        end
        if (BUS.wr)
        begin
            case (BUS.addr)
                `OFS_CONTROL:
                begin
                    next_st.enable = BUS.wdata[`BIT_ENABLE];
                    next_st.polarity = BUS.wdata[`BIT_POLARITY];
                    next_st.pfm = BUS.wdata[`BIT_PFM];
                end
                `OFS_CLOCK_CTRL:
                begin
                    next_st.pws = BUS.wdata[`PWS_MSB:`PWS_LSB];
                    next_st.cks = BUS.wdata[`CKS_MSB:`CKS_LSB];
                end
                `OFS_ACC_LOW: next_st.acc[7:0] = BUS.wdata;
                `OFS_ACC_HIGH: next_st.acc[15:8] = BUS.wdata;
                `OFS_ACC_UPPER: next_st.acc[19:16] = BUS.wdata[3:0];
                `OFS_INC_LOW:
                begin
                    next_st.inc[7:0] = BUS.wdata;
                    next_st.inc_pending = 1'b1;
                end
                `OFS_INC_HIGH: next_st.inc[15:8] = BUS.wdata;
                `OFS_INC_UPPER: next_st.inc[19:16] = BUS.wdata[3:0];
                default:
                begin
                end
            endcase
        end
        next_st.rdata = 8'h00;
        if (BUS.rd)
        begin
            case (BUS.addr)
                `OFS_CONTROL:
                begin
                    next_st.rdata[`BIT_ENABLE] = st.enable;
                    next_st.rdata[`BIT_OUT_STATUS] = st.out;
                    next_st.rdata[`BIT_POLARITY] = st.polarity;
                    next_st.rdata[`BIT_PFM] = st.pfm;
                end
                `OFS_CLOCK_CTRL: next_st.rdata = {st.pws, 2'h0, st.cks};
                `OFS_ACC_LOW: next_st.rdata = st.acc[7:0];
                `OFS_ACC_HIGH: next_st.rdata = st.acc[15:8];
                `OFS_ACC_UPPER: next_st.rdata = {4'h0, st.acc[19:16]};
                `OFS_INC_LOW: next_st.rdata = st.inc[7:0];
                `OFS_INC_HIGH: next_st.rdata = st.inc[15:8];
                `OFS_INC_UPPER: next_st.rdata = {4'h0, st.inc[19:16]};
                default: next_st.rdata = 8'h00;
            endcase
        end
        next_st.pin = next_st.out ^ next_st.polarity;
    end

    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st <= '0;
            st.acc <= `RST_ACC;
            st.inc <= `RST_INC;
            st.increment_buffer <= `RST_INC;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign RDATA = st.rdata;
    assign NCO_OUT = st.pin;

    // ----------------------------------------
    // checks: register bus
    // ----------------------------------------
    a_upper_nibble: assert property (@(posedge CLK) disable iff (!rst_n)
        BUS.rd && BUS.addr == `OFS_ACC_UPPER |=> RDATA == {4'h0, $past(st.acc[19:16])})
        else $error("upper accumulator byte read wrong");

    a_unmapped_zero: assert property (@(posedge CLK) disable iff (!rst_n)
        BUS.rd && BUS.addr > `OFS_INC_UPPER |=> RDATA == 8'h00)
        else $error("unmapped read not zero");

    // read data stand one cycle only, so a late sample sees zero
    a_rdata_idle: assert property (@(posedge CLK) disable iff (!rst_n)
        !BUS.rd |=> RDATA == 8'h00)
        else $error("read data without read strobe");

    a_clock_read: assert property (@(posedge CLK) disable iff (!rst_n)
        BUS.rd && BUS.addr == `OFS_CLOCK_CTRL |=> RDATA[4:3] == 2'h0)
        else $error("unused clock control bits not zero");

    a_status_read: assert property (@(posedge CLK) disable iff (!rst_n)
        BUS.rd && BUS.addr == `OFS_CONTROL |=> RDATA[`BIT_OUT_STATUS] == $past(st.out))
        else $error("output status bit wrong");

    a_low_write: assert property (@(posedge CLK) disable iff (!rst_n)
        BUS.wr && BUS.addr == `OFS_ACC_LOW |=> st.acc[7:0] == $past(BUS.wdata))
        else $error("accumulator low write lost");

    a_low_read: assert property (@(posedge CLK) disable iff (!rst_n)
        BUS.rd && BUS.addr == `OFS_ACC_LOW |=> RDATA == $past(st.acc[7:0]))
        else $error("accumulator low read wrong");

    a_high_write: assert property (@(posedge CLK) disable iff (!rst_n)
        BUS.wr && BUS.addr == `OFS_ACC_HIGH |=> st.acc[15:8] == $past(BUS.wdata))
        else $error("accumulator high write lost");

    a_high_read: assert property (@(posedge CLK) disable iff (!rst_n)
        BUS.rd && BUS.addr == `OFS_ACC_HIGH |=> RDATA == $past(st.acc[15:8]))
        else $error("accumulator high read wrong");

    a_upper_write: assert property (@(posedge CLK) disable iff (!rst_n)
        BUS.wr && BUS.addr == `OFS_ACC_UPPER |=> st.acc[19:16] == $past(BUS.wdata[3:0]))
        else $error("accumulator upper write lost");

    // ----------------------------------------
    // checks: accumulator and sources
    // ----------------------------------------
    a_disabled_hold: assert property (@(posedge CLK) disable iff (!rst_n)
        !st.enable && !acc_written |=> $stable(st.acc) && !st.out)
        else $error("accumulator moved while disabled");

    a_accum_add: assert property (@(posedge CLK) disable iff (!rst_n)
        st.enable && tick_rise && !acc_written |=> st.acc == $past(sum[19:0]))
        else $error("accumulator add wrong");

    a_system_source: assert property (@(posedge CLK) disable iff (!rst_n)
        st.enable && st.cks == `CKS_SYSTEM && !acc_written |=> st.acc == $past(sum[19:0]))
        else $error("system clock source did not add");

    a_fast_source: assert property (@(posedge CLK) disable iff (!rst_n)
        st.cks == `CKS_FAST_OSC && !src_rise[0] && !acc_written |=> $stable(st.acc))
        else $error("accumulator moved without source edge");

    // reserved codes have no source, so only a bus write may move the accumulator
    a_reserved_frozen: assert property (@(posedge CLK) disable iff (!rst_n)
        st.cks > `CKS_LC_LAST && !acc_written |=> $stable(st.acc))
        else $error("accumulator moved on reserved source");

    a_inc_copy: assert property (@(posedge CLK) disable iff (!rst_n)
        st.inc_pending && tick_fall |=> st.increment_buffer == $past(st.inc))
        else $error("increment buffer not loaded");

    a_inc_hold: assert property (@(posedge CLK) disable iff (!rst_n)
        !st.inc_pending |=> $stable(st.increment_buffer))
        else $error("increment buffer changed without low write");

    a_pending_set: assert property (@(posedge CLK) disable iff (!rst_n)
        BUS.wr && BUS.addr == `OFS_INC_LOW |=> st.inc_pending)
        else $error("low increment write did not arm copy");

    // ----------------------------------------
    // checks: output
    // ----------------------------------------
    a_fdc_toggle: assert property (@(posedge CLK) disable iff (!rst_n)
        overflow && !st.pfm && !BUS.wr |=> st.out != $past(st.out))
        else $error("fixed duty output did not toggle");

    a_fdc_hold: assert property (@(posedge CLK) disable iff (!rst_n)
        st.enable && !st.pfm && !overflow && !BUS.wr |=> $stable(st.out))
        else $error("fixed duty output moved without overflow");

    a_pws_ignored: assert property (@(posedge CLK) disable iff (!rst_n)
        st.enable && !st.pfm && !BUS.wr |=> $stable(st.width_cnt))
        else $error("pulse counter used in fixed duty mode");

    a_pfm_start: assert property (@(posedge CLK) disable iff (!rst_n)
        overflow && st.pfm && !BUS.wr |=> st.out && NCO_OUT == !st.polarity)
        else $error("pulse not started on overflow");

    a_pfm_load: assert property (@(posedge CLK) disable iff (!rst_n)
        overflow && st.pfm && st.pws == 3'h6 |=> st.width_cnt == 8'h3f)
        else $error("pulse counter not loaded for 64 periods");

    a_pulse_count: assert property (@(posedge CLK) disable iff (!rst_n)
        st.pfm && st.enable && st.out && tick_rise && !overflow && st.width_cnt != 8'h00
        && !BUS.wr |=> st.width_cnt == $past(st.width_cnt) - 8'h01)
        else $error("pulse counter did not count down");

    a_pfm_end: assert property (@(posedge CLK) disable iff (!rst_n)
        st.pfm && st.enable && st.out && tick_rise && !sum[20] && st.width_cnt == 8'h00
        && !BUS.wr |=> !st.out)
        else $error("pulse longer than its width");

    a_out_disabled: assert property (@(posedge CLK) disable iff (!rst_n)
        !st.enable |=> !st.out)
        else $error("output active while disabled");
endmodule

// File: tb/numeric_oscillator_bench.sv
`timescale 1ns/1ps
`include "nco_params.svh"
module numeric_oscillator_bench;
    import nco_pkg::*;
    logic CLK = 1'b0;
    logic RST_N = 1'b0;
    bus_req_t BUS = '0;
    logic [7:0] RDATA;
    logic FAST_OSC = 1'b0;
    logic [3:0] LC_OUT = 4'h0;
    logic NCO_OUT;
    int fails = 0;
    int num_checks = 0;

    numeric_oscillator numeric_oscillator_inst
    (
        .CLK(CLK),
        .RST_N(RST_N),
        .BUS(BUS),
        .RDATA(RDATA),
        .FAST_OSC(FAST_OSC),
        .LC_OUT(LC_OUT),
        .NCO_OUT(NCO_OUT)
    );

    always #50 CLK = ~CLK;

    // ----------------------------------------
    // verdict and compares
    // ----------------------------------------
    task print_verdict;
        if (fails == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task chk_byte(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("Error at %0t: byte %h, expected %h", $time, got, exp);
        end
    endtask

    task chk_count(input int got, input int exp);
        num_checks++;
        if (got != exp)
        begin
            fails++;
            $display("Error at %0t: count %0d, expected %0d", $time, got, exp);
        end
    endtask

    // ----------------------------------------
    // bus cycles
    // ----------------------------------------
    // one idle cycle after each strobe so no signal is assigned twice per step
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge CLK);
        BUS <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge CLK);
        BUS.wr <= 1'b0;
    endtask

    task rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge CLK);
        BUS <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge CLK);
        BUS.rd <= 1'b0;
        #1 d = RDATA;
    endtask

    task rchk(input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk_byte(d, exp);
    endtask

    task set_acc(input logic [19:0] v);
        wr(`OFS_ACC_LOW, v[7:0]);
        wr(`OFS_ACC_HIGH, v[15:8]);
        wr(`OFS_ACC_UPPER, {4'h0, v[19:16]});
    endtask

    task set_inc(input logic [19:0] v);
        wr(`OFS_INC_UPPER, {4'h0, v[19:16]});
        wr(`OFS_INC_HIGH, v[15:8]);
        wr(`OFS_INC_LOW, v[7:0]);
    endtask

    // reserved codes toggle every source so a stray mapping shows up
    task drive_src(input int code, input logic v);
        if (code == 1)
            FAST_OSC <= v;
        else if (code >= 2 && code <= 5)
            LC_OUT[code - 2] <= v;
        else
        begin
            FAST_OSC <= v;
            LC_OUT <= {4{v}};
        end
    endtask

    task count_high(output int n);
        int i;
        n = 0;
        i = 0;
        while (NCO_OUT !== 1'b1 && i < 8000)
        begin
            @(posedge CLK);
            i++;
        end
        while (NCO_OUT === 1'b1 && n < 8000)
        begin
            @(posedge CLK);
            n++;
        end
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_regs;
        rchk(`OFS_ACC_LOW, 8'h00);
        rchk(`OFS_ACC_HIGH, 8'h00);
        rchk(`OFS_ACC_UPPER, 8'h00);
        rchk(4'h8, 8'h00);
        set_acc(20'hfffff);
        wr(`OFS_ACC_LOW, 8'ha5);
        wr(`OFS_ACC_HIGH, 8'h5a);
        wr(`OFS_ACC_UPPER, 8'hff);
        rchk(`OFS_ACC_LOW, 8'ha5);
        rchk(`OFS_ACC_HIGH, 8'h5a);
        rchk(`OFS_ACC_UPPER, 8'h0f);
        wr(`OFS_CLOCK_CTRL, 8'hfd);
        rchk(`OFS_CLOCK_CTRL, 8'he5);
        set_acc(20'h00000);
    endtask

    task t_running;
        logic [7:0] a;
        logic [7:0] b;
        wr(`OFS_CLOCK_CTRL, 8'h00);
        wr(`OFS_CONTROL, 8'h80);
        rd(`OFS_ACC_LOW, a);
        rd(`OFS_ACC_LOW, b);
        chk_byte(b, a + 8'h02);
        wr(`OFS_CONTROL, 8'h00);
        rd(`OFS_ACC_LOW, a);
        repeat (10) @(posedge CLK);
        rd(`OFS_ACC_LOW, b);
        chk_byte(b, a);
    endtask

    task t_sources;
        for (int code = 1; code <= 6; code++)
        begin
            wr(`OFS_CONTROL, 8'h00);
            set_acc(20'h00000);
            wr(`OFS_CLOCK_CTRL, code[7:0]);
            wr(`OFS_CONTROL, 8'h80);
            repeat (5)
            begin
                repeat (4) @(posedge CLK);
                drive_src(code, 1'b1);
                repeat (4) @(posedge CLK);
                drive_src(code, 1'b0);
            end
            repeat (12) @(posedge CLK);
            rchk(`OFS_ACC_LOW, (code < 6) ? 8'h05 : 8'h00);
        end
    endtask

    // overflow every 4096 cycles keeps the widest pulse well inside the period
    task t_pulse;
        int n;
        wr(`OFS_CONTROL, 8'h00);
        set_inc(20'h00100);
        for (int pws = 0; pws < 8; pws++)
        begin
            wr(`OFS_CONTROL, 8'h00);
            set_acc(20'hfff00);
            wr(`OFS_CLOCK_CTRL, 8'(pws << 5));
            wr(`OFS_CONTROL, 8'h81);
            count_high(n);
            chk_count(n, 1 << pws);
        end
    endtask

    task t_fixed_duty;
        int n;
        wr(`OFS_CONTROL, 8'h00);
        set_acc(20'hfff00);
        wr(`OFS_CLOCK_CTRL, 8'h60);
        wr(`OFS_CONTROL, 8'h80);
        count_high(n);
        chk_count(n, 4096);
        wr(`OFS_CONTROL, 8'h00);
    endtask

    // inverted polarity while disabled: pin idles high, status reads back
    task t_polarity;
        wr(`OFS_CONTROL, 8'h10);
        @(posedge CLK);
        chk_byte({7'h00, NCO_OUT}, 8'h01);
        rchk(`OFS_CONTROL, 8'h10);
        wr(`OFS_CONTROL, 8'h00);
    endtask

    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial
    begin
        repeat (10) @(posedge CLK);
        RST_N <= 1'b1;
        repeat (5) @(posedge CLK);
        t_regs;
        t_running;
        t_sources;
        t_pulse;
        t_fixed_duty;
        t_polarity;
        print_verdict;
    end

    // about 5000 cycles expected; generous margin
    initial
    begin
        #5_000_000;
        fails++;
        $display("Error at %0t: watchdog expired", $time);
        print_verdict;
    end
endmodule
